// file: iegc_pkg.sv
// Package: register map, field layouts and timing for the bus controller
`default_nettype none
package iegc_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [4:0] OFS_OWN_ADR = 5'h00;
  localparam logic [4:0] OFS_PRI_CTL = 5'h04;
  localparam logic [4:0] OFS_SEC_CTL = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0c;
  localparam logic [4:0] OFS_DATA = 5'h10;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [9:0] OWN_ADR_RST = 10'h000;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  // ----------------------------------------
  // Bus constants
  // ----------------------------------------
  localparam logic [7:0] GEN_CALL_ADR = 8'h00;
  localparam logic [4:0] TEN_BIT_HDR = 5'h1e;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 50;
  localparam int SCL_HALF_NS = 5000;
  localparam int HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);
  // ----------------------------------------
  // Field layouts
  // ----------------------------------------
  typedef struct packed {
    logic module_enable_bit;
    logic bus_interrupt_enable;
    logic mst;
    logic tx;
    logic txak;
    logic rsta;
    logic [1:0] rsv;
  } iegc_pri_t;
  typedef struct packed {
    logic general_call_enable;
    logic ten_bit;
    logic [5:0] rsv;
  } iegc_sec_t;
  typedef struct packed {
    logic transfer_complete_flag;
    logic addressed_as_slave_flag;
    logic busy;
    logic arbitration_lost_flag;
    logic rsv;
    logic slave_read_write_indication;
    logic bus_interrupt_flag;
    logic rxak;
  } iegc_stat_t;
  // ----------------------------------------
  // Master sequencer states
  // ----------------------------------------
  typedef enum logic [3:0] {
    M_IDLE = 4'h0,
    M_START = 4'h1,
    M_HOLD = 4'h2,
    M_LOW = 4'h3,
    M_HIGH = 4'h4,
    M_STOP1 = 4'h5,
    M_STOP2 = 4'h6,
    M_RS1 = 4'h7,
    M_RS2 = 4'h8,
    M_RS3 = 4'h9
  } iegc_mst_t;
endpackage
`default_nettype wire

// file: iegc_ctrl.sv
// Two-wire bus controller: events, general call, arbitration, Avalon slave
// Function
// - General call accepted in 7-bit or 10-bit mode
// - General call enable adds general call match
// - General call: slave receiver, flag after address
// - General call disabled: no acknowledge
// - Controller disabled after system reset
// - No path to reset the microcontroller
// - One interrupt output for all sources
// - Interrupt is flag gated by enable
// - Interrupt flag cleared only by writing one
// - Transfer complete at ninth clock falling edge
// - Address match or enabled general call flags
// - Lost arbitration sets flag and interrupt
// - Lost when driven high data reads low
// - Lost when driven high acknowledge reads low
// - Lost when start requested on busy bus
// - Lost when repeated start requested as slave
// - Lost on stop the master did not request
// - Arbitration flag cleared only by writing one
// - Lost master becomes slave receiver, releases data
`default_nettype none
module iegc_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Interrupt
  output logic irq
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [2:0] scl_sy_ff, sda_sy_ff;
  logic scl_s, scl_p, sda_s, sda_p;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic req_go, wr_go, rd_go;
  logic [31:0] rd_word;
  iegc_pkg::iegc_pri_t pri_ff, wpri;
  iegc_pkg::iegc_sec_t sec_ff;
  iegc_pkg::iegc_stat_t stat, wstat;
  logic [9:0] own_adr_ff;
  logic [7:0] tx_dat_ff, rx_dat_ff, sh_ff;
  logic transfer_complete_flag_ff, addressed_as_slave_flag_ff;
  logic arbitration_lost_flag_ff, bus_interrupt_flag_ff;
  logic slave_read_write_indication_ff;
  logic busy_ff, rxak_ff, irq_ff, zero_ff;
  logic frame_ff, first_ff, addr_ph_ff, ten_wait_ff, ten_ok_ff;
  logic ack_ff, hit_ff, part_ff, hit_rw_ff, slv_ff;
  logic [3:0] cnt_ff, mbit_ff;
  logic [7:0] mcnt_ff;
  logic scl_low_ff, msda_low_ff, scl_oe_n_ff, sda_oe_n_ff;
  logic go_ff, stp_ff, rs_ff, wait_ff;
  iegc_pkg::iegc_mst_t mst_st_ff;
  logic en, we_tx, bit_hi, eng_low, m_quiet, half_done;
  logic involved, byte_done, byte8;
  logic lose_bit, lose_start, lose_rsta, lose_stop, lost;
  logic gc, hdr_hit, nxt_hit, nxt_part, nxt_rw, nxt_ack;
  logic set_tc, set_aas;

  function automatic logic sel(input logic [4:0] a, input logic [4:0] o);
    sel = (a == o);
  endfunction

  // ----------------------------------------
  // Pin synchronisers and bus conditions
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      scl_sy_ff <= 3'h7;
      sda_sy_ff <= 3'h7;
    end else begin
      scl_sy_ff <= {scl_sy_ff[1:0], scl_in};
      sda_sy_ff <= {sda_sy_ff[1:0], sda_in};
    end
  end
  assign scl_s = scl_sy_ff[1];
  assign scl_p = scl_sy_ff[2];
  assign sda_s = sda_sy_ff[1];
  assign sda_p = sda_sy_ff[2];
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_det = en & scl_s & scl_p & ~sda_s & sda_p;
  assign stop_det = en & scl_s & scl_p & sda_s & ~sda_p;

  // ----------------------------------------
  // Avalon access
  // ----------------------------------------
  assign req_go = (avs_read | avs_write) & ~wait_ff;
  assign wr_go = avs_write & ~wait_ff;
  assign rd_go = avs_read & ~wait_ff;
  assign wpri = iegc_pkg::iegc_pri_t'(avs_writedata[7:0]);
  assign wstat = iegc_pkg::iegc_stat_t'(avs_writedata[7:0]);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= ~((avs_read | avs_write) & wait_ff) | req_go;
    end
  end

  always_comb begin
    stat = '0;
    stat.transfer_complete_flag = transfer_complete_flag_ff;
    stat.addressed_as_slave_flag = addressed_as_slave_flag_ff;
    stat.busy = busy_ff;
    stat.arbitration_lost_flag = arbitration_lost_flag_ff;
    stat.slave_read_write_indication = slave_read_write_indication_ff;
    stat.bus_interrupt_flag = bus_interrupt_flag_ff;
    stat.rxak = rxak_ff;
    case (avs_address)
      iegc_pkg::OFS_OWN_ADR: rd_word = {22'h0, own_adr_ff};
      iegc_pkg::OFS_PRI_CTL: rd_word = {24'h000000, pri_ff};
      iegc_pkg::OFS_SEC_CTL: rd_word = {24'h000000, sec_ff};
      iegc_pkg::OFS_STATUS: rd_word = {24'h000000, stat};
      iegc_pkg::OFS_DATA: rd_word = {24'h000000, rx_dat_ff};
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & wait_ff) begin
      avs_readdata <= rd_word;
    end
  end
  assign avs_waitrequest = wait_ff;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  assign en = pri_ff.module_enable_bit;
  assign lose_start = wr_go & sel(avs_address, iegc_pkg::OFS_PRI_CTL)
    & wpri.mst & ~pri_ff.mst & busy_ff & en;
  assign lose_rsta = wr_go & sel(avs_address, iegc_pkg::OFS_PRI_CTL)
    & wpri.rsta & ~pri_ff.mst & en;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pri_ff <= iegc_pkg::iegc_pri_t'(iegc_pkg::CTL_RST);
      sec_ff <= iegc_pkg::iegc_sec_t'(iegc_pkg::CTL_RST);
      own_adr_ff <= iegc_pkg::OWN_ADR_RST;
      tx_dat_ff <= iegc_pkg::DATA_RST;
    end else begin
      if (wr_go & sel(avs_address, iegc_pkg::OFS_PRI_CTL)) begin
        pri_ff <= wpri;
        pri_ff.rsta <= 1'b0;
        pri_ff.rsv <= 2'h0;
        if (lose_start) begin
          pri_ff.mst <= 1'b0;
        end
      end
      if (lost) begin
        pri_ff.mst <= 1'b0;
        pri_ff.tx <= 1'b0;
      end
      if (wr_go & sel(avs_address, iegc_pkg::OFS_SEC_CTL)) begin
        sec_ff <= iegc_pkg::iegc_sec_t'({avs_writedata[7:6], 6'h00});
      end
      if (wr_go & sel(avs_address, iegc_pkg::OFS_OWN_ADR)) begin
        own_adr_ff <= avs_writedata[9:0];
      end
      if (wr_go & sel(avs_address, iegc_pkg::OFS_DATA)) begin
        tx_dat_ff <= avs_writedata[7:0];
      end
    end
  end

  // ----------------------------------------
  // Bit engine
  // ----------------------------------------
  assign we_tx = (pri_ff.mst & pri_ff.tx)
    | (slv_ff & slave_read_write_indication_ff & ~rxak_ff);
  assign bit_hi = tx_dat_ff[3'(iegc_pkg::LAST_DATA_BIT - cnt_ff)];
  assign eng_low = frame_ff & ~first_ff & (we_tx
    ? (cnt_ff < iegc_pkg::ACK_BIT) & ~bit_hi
    : (cnt_ff == iegc_pkg::ACK_BIT) & ack_ff);
  assign byte8 = scl_fall & frame_ff & ~first_ff
    & (cnt_ff == iegc_pkg::LAST_DATA_BIT);
  assign byte_done = scl_fall & frame_ff & ~first_ff
    & (cnt_ff == iegc_pkg::ACK_BIT);
  assign involved = pri_ff.mst | slv_ff | hit_ff | part_ff;

  always_comb begin
    gc = (sh_ff == iegc_pkg::GEN_CALL_ADR);
    hdr_hit = (sh_ff[7:3] == iegc_pkg::TEN_BIT_HDR)
      & (sh_ff[2:1] == own_adr_ff[9:8]);
    nxt_hit = 1'b0;
    nxt_part = 1'b0;
    nxt_rw = 1'b0;
    nxt_ack = 1'b0;
    if (addr_ph_ff & ~pri_ff.mst) begin
      if (gc) begin
        nxt_hit = sec_ff.general_call_enable;
      end else if (~sec_ff.ten_bit) begin
        nxt_hit = (sh_ff[7:1] == own_adr_ff[6:0]);
        nxt_rw = sh_ff[0];
      end else if (~sh_ff[0]) begin
        nxt_part = hdr_hit;
      end else begin
        nxt_hit = hdr_hit & ten_ok_ff;
        nxt_rw = 1'b1;
      end
      nxt_ack = nxt_hit | nxt_part;
    end else if (ten_wait_ff) begin
      nxt_hit = (sh_ff == own_adr_ff[7:0]);
      nxt_ack = nxt_hit;
    end else begin
      nxt_ack = ((slv_ff & ~slave_read_write_indication_ff)
        | (pri_ff.mst & ~pri_ff.tx)) & ~pri_ff.txak;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst | ~en | stop_det) begin
      frame_ff <= 1'b0;
      first_ff <= 1'b0;
      cnt_ff <= 4'h0;
      addr_ph_ff <= 1'b0;
      ten_wait_ff <= 1'b0;
      ten_ok_ff <= 1'b0;
      ack_ff <= 1'b0;
      hit_ff <= 1'b0;
      part_ff <= 1'b0;
      hit_rw_ff <= 1'b0;
      slv_ff <= 1'b0;
    end else if (start_det) begin
      frame_ff <= 1'b1;
      first_ff <= 1'b1;
      cnt_ff <= 4'h0;
      addr_ph_ff <= 1'b1;
      ten_wait_ff <= 1'b0;
      ack_ff <= 1'b0;
      slv_ff <= 1'b0;
    end else if (scl_fall & frame_ff & first_ff) begin
      first_ff <= 1'b0;
    end else if (byte8) begin
      cnt_ff <= iegc_pkg::ACK_BIT;
      ack_ff <= nxt_ack;
      hit_ff <= nxt_hit;
      part_ff <= nxt_part;
      hit_rw_ff <= nxt_rw;
    end else if (byte_done) begin
      cnt_ff <= 4'h0;
      ack_ff <= 1'b0;
      hit_ff <= 1'b0;
      part_ff <= 1'b0;
      addr_ph_ff <= 1'b0;
      ten_wait_ff <= part_ff;
      if (hit_ff) begin
        slv_ff <= 1'b1;
        ten_ok_ff <= ten_wait_ff | ten_ok_ff;
      end
    end else if (scl_fall & frame_ff) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sh_ff <= 8'h00;
      rxak_ff <= 1'b0;
      rx_dat_ff <= iegc_pkg::DATA_RST;
      slave_read_write_indication_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      if (scl_rise & frame_ff & ~first_ff) begin
        if (cnt_ff < iegc_pkg::ACK_BIT) begin
          sh_ff <= {sh_ff[6:0], sda_s};
        end else begin
          rxak_ff <= sda_s;
        end
      end
      if (byte_done & involved) begin
        rx_dat_ff <= sh_ff;
      end
      if (byte_done & hit_ff) begin
        slave_read_write_indication_ff <= hit_rw_ff;
        rxak_ff <= 1'b0;
      end
      if (start_det) begin
        busy_ff <= 1'b1;
      end else if (stop_det | ~en) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  assign m_quiet = (mst_st_ff == iegc_pkg::M_STOP1)
    | (mst_st_ff == iegc_pkg::M_STOP2) | (mst_st_ff == iegc_pkg::M_RS1)
    | (mst_st_ff == iegc_pkg::M_RS2) | (mst_st_ff == iegc_pkg::M_RS3);
  assign lose_bit = scl_rise & frame_ff & ~first_ff & pri_ff.mst
    & ~m_quiet & ~sda_s & (pri_ff.tx
    ? (cnt_ff < iegc_pkg::ACK_BIT) & bit_hi
    : (cnt_ff == iegc_pkg::ACK_BIT) & ~ack_ff);
  assign lose_stop = stop_det & pri_ff.mst & ~m_quiet;
  // Any arbitration loss
  assign lost = lose_bit | lose_stop | lose_start | lose_rsta;

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // ninth falling edge
  assign set_tc = byte_done & involved;
  assign set_aas = byte_done & hit_ff;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      transfer_complete_flag_ff <= 1'b0;
    end else if (set_tc) begin
      transfer_complete_flag_ff <= 1'b1;
    end else if (req_go & sel(avs_address, iegc_pkg::OFS_DATA)) begin
      transfer_complete_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      addressed_as_slave_flag_ff <= 1'b0;
    end else if (set_aas) begin
      addressed_as_slave_flag_ff <= 1'b1;
    end else if (start_det | stop_det
      | (wr_go & sel(avs_address, iegc_pkg::OFS_PRI_CTL))) begin
      addressed_as_slave_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      arbitration_lost_flag_ff <= 1'b0;
    end else if (lost) begin
      arbitration_lost_flag_ff <= 1'b1;
    end else if (wr_go & sel(avs_address, iegc_pkg::OFS_STATUS)
      & wstat.arbitration_lost_flag) begin
      arbitration_lost_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bus_interrupt_flag_ff <= 1'b0;
    end else if (set_tc | set_aas | lost) begin
      bus_interrupt_flag_ff <= 1'b1;
    end else if (wr_go & sel(avs_address, iegc_pkg::OFS_STATUS)
      & wstat.bus_interrupt_flag) begin
      bus_interrupt_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= bus_interrupt_flag_ff & pri_ff.bus_interrupt_enable;
    end
  end
  assign irq = irq_ff;

  // ----------------------------------------
  // Master requests
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst | lost | ~en | (mst_st_ff == iegc_pkg::M_IDLE)) begin
      go_ff <= 1'b0;
      stp_ff <= 1'b0;
      rs_ff <= 1'b0;
    end else if (mst_st_ff == iegc_pkg::M_HOLD
      & (go_ff | stp_ff | rs_ff)) begin
      go_ff <= 1'b0;
      stp_ff <= 1'b0;
      rs_ff <= 1'b0;
    end else begin
      if ((wr_go & sel(avs_address, iegc_pkg::OFS_DATA))
        | (rd_go & sel(avs_address, iegc_pkg::OFS_DATA) & ~pri_ff.tx)) begin
        go_ff <= 1'b1;
      end
      if (wr_go & sel(avs_address, iegc_pkg::OFS_PRI_CTL)) begin
        stp_ff <= ~wpri.mst;
        rs_ff <= wpri.rsta & wpri.mst;
      end
    end
  end

  // ----------------------------------------
  // Master sequencer
  // ----------------------------------------
  assign half_done = (mcnt_ff == iegc_pkg::HALF_LAST);

  always_ff @(posedge clk_sys) begin
    if (sys_rst | lost | ~en) begin
      mst_st_ff <= iegc_pkg::M_IDLE;
      mcnt_ff <= 8'h00;
      mbit_ff <= 4'h0;
      scl_low_ff <= 1'b0;
      msda_low_ff <= 1'b0;
    end else begin
      mcnt_ff <= half_done ? 8'h00 : mcnt_ff + 8'h01;
      case (mst_st_ff)
        iegc_pkg::M_IDLE: begin
          mcnt_ff <= 8'h00;
          if (wr_go & sel(avs_address, iegc_pkg::OFS_PRI_CTL)
            & wpri.mst & ~pri_ff.mst & ~busy_ff) begin
            msda_low_ff <= 1'b1;
            mst_st_ff <= iegc_pkg::M_START;
          end
        end
        iegc_pkg::M_START: begin
          if (half_done) begin
            scl_low_ff <= 1'b1;
            mst_st_ff <= iegc_pkg::M_HOLD;
          end
        end
        iegc_pkg::M_HOLD: begin
          mcnt_ff <= 8'h00;
          if (stp_ff) begin
            msda_low_ff <= 1'b1;
            mst_st_ff <= iegc_pkg::M_STOP1;
          end else if (rs_ff) begin
            msda_low_ff <= 1'b0;
            mst_st_ff <= iegc_pkg::M_RS1;
          end else if (go_ff) begin
            msda_low_ff <= 1'b0;
            mbit_ff <= 4'h0;
            mst_st_ff <= iegc_pkg::M_LOW;
          end
        end
        iegc_pkg::M_LOW: begin
          if (half_done) begin
            scl_low_ff <= 1'b0;
            mst_st_ff <= iegc_pkg::M_HIGH;
          end
        end
        iegc_pkg::M_HIGH: begin
          if (~scl_s) begin
            mcnt_ff <= 8'h00;
          end else if (half_done) begin
            scl_low_ff <= 1'b1;
            mbit_ff <= mbit_ff + 4'h1;
            if (mbit_ff == iegc_pkg::ACK_BIT) begin
              mst_st_ff <= iegc_pkg::M_HOLD;
            end else begin
              mst_st_ff <= iegc_pkg::M_LOW;
            end
          end
        end
        iegc_pkg::M_STOP1: begin
          if (half_done) begin
            scl_low_ff <= 1'b0;
            mst_st_ff <= iegc_pkg::M_STOP2;
          end
        end
        iegc_pkg::M_STOP2: begin
          if (~scl_s) begin
            mcnt_ff <= 8'h00;
          end else if (half_done) begin
            msda_low_ff <= 1'b0;
            mst_st_ff <= iegc_pkg::M_IDLE;
          end
        end
        iegc_pkg::M_RS1: begin
          if (half_done) begin
            scl_low_ff <= 1'b0;
            mst_st_ff <= iegc_pkg::M_RS2;
          end
        end
        iegc_pkg::M_RS2: begin
          if (~scl_s) begin
            mcnt_ff <= 8'h00;
          end else if (half_done) begin
            msda_low_ff <= 1'b1;
            mst_st_ff <= iegc_pkg::M_RS3;
          end
        end
        iegc_pkg::M_RS3: begin
          if (half_done) begin
            scl_low_ff <= 1'b1;
            mst_st_ff <= iegc_pkg::M_HOLD;
          end
        end
        default: begin
          mst_st_ff <= iegc_pkg::M_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // lost master stops driving data
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      scl_oe_n_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1;
      zero_ff <= 1'b0;
    end else begin
      scl_oe_n_ff <= ~(en & scl_low_ff & ~lost);
      sda_oe_n_ff <= ~(en & ~lost
        & ((eng_low & ~m_quiet) | msda_low_ff));
      zero_ff <= 1'b0;
    end
  end
  assign scl_oe_n = scl_oe_n_ff;
  assign sda_oe_n = sda_oe_n_ff;
  assign scl_out = zero_ff;
  assign sda_out = zero_ff;
endmodule
`default_nettype wire

// file: iegc_chk_sva.sv
// Checker: port-level properties of the two-wire bus controller
`default_nettype none
module iegc_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  // Bus pins and interrupt
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_ok, ctl_wr, clr_wr, en_seen_ff;
  assign wr_ok = avs_write & ~avs_waitrequest;
  assign ctl_wr = wr_ok & (avs_address == iegc_pkg::OFS_PRI_CTL);
  assign clr_wr = ctl_wr | (wr_ok & (avs_address == iegc_pkg::OFS_STATUS));
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      en_seen_ff <= 1'h0;
    end else if (ctl_wr && avs_writedata[7]) begin
      en_seen_ff <= 1'h1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  chk_rst_quiet: assert property (
    $past(sys_rst) |-> avs_waitrequest && !irq && sda_oe_n && scl_oe_n)
    else $error("outputs active after reset");
  chk_dis_quiet: assert property (
    !en_seen_ff |-> sda_oe_n && scl_oe_n)
    else $error("pins driven while disabled");
  chk_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  chk_wait_pulse: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_irq_mask: assert property (
    ctl_wr && !avs_writedata[6] |=> ##1 !irq)
    else $error("irq not masked");
  chk_irq_clear: assert property (
    $fell(irq) && !$past(sys_rst) |-> $past(clr_wr, 2))
    else $error("irq fell without clear");
  chk_irq_hold: assert property (
    irq && !clr_wr && !$past(clr_wr) |=> irq)
    else $error("irq dropped");
  chk_open_drain: assert property (
    scl_out == 1'h0 && sda_out == 1'h0)
    else $error("pin driven high");
  cover property ($rose(irq));
  cover property ($fell(sda_oe_n));
  cover property (wr_ok && avs_address == 5'h14);
endmodule
`default_nettype wire

// file: iegc_bus_mdl.sv
// Far-side master model for the two-wire bus
`default_nettype none
module iegc_bus_mdl (
  // Wire levels
  input wire logic scl_w,
  input wire logic sda_w,
  // Drive, 1 = released
  output var logic scl_m,
  output var logic sda_m
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_m = 1'h1;
    sda_m = 1'h1;
  end
  task automatic pull(input logic v);
    sda_m <= v;
  endtask
  task automatic start();
    #13 sda_m = 1'h0;
    #200 scl_m = 1'h0;
  endtask
  task automatic bit_io(input logic v, output logic s);
    #100 sda_m = v;
    #100 scl_m = 1'h1;
    #100 s = sda_w;
    #100 scl_m = 1'h0;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'h1, ack);
    #400;
  endtask
  task automatic stop();
    #100 sda_m = 1'h0;
    #100 scl_m = 1'h1;
    #200 sda_m = 1'h1;
    #200;
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Testbench: register access, general call, address match, arbitration
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest, irq;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, scl_m, sda_m;
  int error_cnt, checked;
  wire scl_w = scl_m & (scl_oe_n | scl_out);
  wire sda_w = sda_m & (sda_oe_n | sda_out);
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("Error %0t: got %h exp %h", $time, a, e); end end
  iegc_ctrl i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .irq(irq));
  iegc_bus_mdl i_bus (.scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m),
    .sda_m(sda_m));
  task automatic stop_test();
    if (error_cnt == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic bail();
    error_cnt++;
    stop_test();
  endtask
  task automatic acc(input logic [4:0] a, input logic w, input logic [7:0] d,
      output logic [31:0] q);
    int n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'h0 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    if (n == 50) bail();
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    acc(a, 1'h1, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] m, e);
    logic [31:0] q;
    acc(a, 1'h0, 8'h00, q);
    `CHK(q & {24'hffffff, m}, {24'h0, e})
  endtask
  task automatic t_reset();
    `CHK({irq, scl_oe_n, sda_oe_n}, 3'h3)
    wr(5'h14, 8'hff);
    rd(iegc_pkg::OFS_PRI_CTL, 8'hff, 8'h00);
    rd(5'h14, 8'hff, 8'h00);
  endtask
  task automatic t_slv(input logic [7:0] sec, adr, st, input logic nak);
    logic ack;
    wr(iegc_pkg::OFS_SEC_CTL, sec);
    wr(iegc_pkg::OFS_OWN_ADR, 8'h2a);
    wr(iegc_pkg::OFS_PRI_CTL, 8'hc0);
    i_bus.start();
    i_bus.send(adr, ack);
    `CHK(ack, nak)
    rd(iegc_pkg::OFS_STATUS, 8'hc6, st);
    `CHK(irq, !nak)
    if (!nak) begin
      rd(iegc_pkg::OFS_DATA, 8'hff, adr);
      wr(iegc_pkg::OFS_PRI_CTL, 8'hc0);
      wr(iegc_pkg::OFS_STATUS, 8'h02);
      rd(iegc_pkg::OFS_STATUS, 8'h82, 8'h00);
      `CHK(irq, 1'h0)
    end
    i_bus.stop();
  endtask
  task automatic t_busy();
    i_bus.start();
    wr(iegc_pkg::OFS_PRI_CTL, 8'he0);
    rd(iegc_pkg::OFS_STATUS, 8'h12, 8'h12);
    rd(iegc_pkg::OFS_PRI_CTL, 8'h20, 8'h00);
    wr(iegc_pkg::OFS_STATUS, 8'h00);
    rd(iegc_pkg::OFS_STATUS, 8'h10, 8'h10);
    wr(iegc_pkg::OFS_STATUS, 8'h12);
    rd(iegc_pkg::OFS_STATUS, 8'h12, 8'h00);
    i_bus.stop();
  endtask
  task automatic t_arb();
    logic [31:0] st;
    int n;
    wr(iegc_pkg::OFS_PRI_CTL, 8'hf0);
    for (n = 0; n < 400 && scl_oe_n !== 1'h0; n++)
      @(posedge clk_sys);
    if (n == 400) bail();
    i_bus.pull(1'h0);
    wr(iegc_pkg::OFS_DATA, 8'hff);
    st = 32'h0;
    for (n = 0; n < 100 && st[4] !== 1'h1; n++)
      acc(iegc_pkg::OFS_STATUS, 1'h0, 8'h00, st);
    if (n == 100) bail();
    `CHK({scl_oe_n, sda_oe_n, st[1]}, 3'h7)
    rd(iegc_pkg::OFS_PRI_CTL, 8'h30, 8'h00);
    `CHK(irq, 1'h1)
    wr(iegc_pkg::OFS_PRI_CTL, 8'h80);
    rd(iegc_pkg::OFS_STATUS, 8'h12, 8'h12);
    `CHK(irq, 1'h0)
    i_bus.pull(1'h1);
    wr(iegc_pkg::OFS_STATUS, 8'h12);
    wr(iegc_pkg::OFS_PRI_CTL, 8'ha4);
    rd(iegc_pkg::OFS_STATUS, 8'h30, 8'h10);
    rd(iegc_pkg::OFS_PRI_CTL, 8'h20, 8'h00);
  endtask
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    error_cnt = 0;
    checked = 0;
    sys_rst = 1'h1;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'h0;
    t_reset();
    t_slv(8'h00, 8'h00, 8'h00, 1'h1);
    t_slv(8'h80, 8'h00, 8'hc2, 1'h0);
    t_slv(8'hc0, 8'h00, 8'hc2, 1'h0);
    t_slv(8'h00, 8'h54, 8'hc2, 1'h0);
    t_busy();
    t_arb();
    stop_test();
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    bail();
  end
endmodule
bind iegc_ctrl iegc_chk i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .irq(irq));
`default_nettype wire
